// >>> rtl/epc_ctrl.sv
// Purpose: Exception and interrupt prioritisation and dispatch to the core.
// Assumes: Fault, call and tick requests are one-cycle pulses on mclk.
// Notes:   Peripheral lines are level, asynchronous, synchronised here.
`timescale 1ns/1ps

// Overview of operation
// - Eight priority levels for seven system handlers and 26 peripheral lines.
// - Settable priority zero ranks right after reset, NMI and hard fault.
// - All settable priority fields reset to zero.
// - Equal priority: lower exception position wins.
// - Reset is position 1, priority -3, drops to base at first instruction.
// - NMI is position 2, priority -2, only reset outranks it.
// - NMI is raised only by a software register write.
// - Hard fault, position 3, catches faults disabled or blocked by priority; a blocked imprecise bus fault stays pending.
// - Memory fault is position 4, settable, raised on protection mismatch.
// - Bus fault is position 5, settable, enableable, precise or imprecise.
// - Usage fault is position 6, settable, on bad instruction or state.
// - Supervisor call is position 11, settable, on the call instruction.
// - Debug monitor is position 12, needs enable, cannot preempt higher.
// - Pendable service request is position 14, pended only by software.
// - System tick is position 15, raised when the tick timer fires.
// - Peripheral interrupts start at position 16, asynchronous, prioritised.
// - Lines 0-12: ports A-E, two serial ports, sync serial, I2C, PWM.
// - Lines 14-24, 28, 29 used; 13, 25-27, 30, 31 reserved.
// - Per-line enable and priority; priorities split into group and sub.
// - Entry stacks state in handler mode; return restores it.
// - Pending exception that outranks the remaining active level at return tail-chains without restore and save.
// - Position 0 gives the initial stack pointer, loaded on reset.
module epc_ctrl (
   // Clock and reset
   input  wire logic                       mclk,
   input  wire logic                       rst_n,
   input  wire logic                       ce,
   // Register port
   input  wire logic [epc_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]                reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [31:0]                reg_rdata,
   // Peripheral lines
   input  wire logic [31:0]                irq_lines,
   // Core event requests
   input  wire logic                       mem_fault_req,
   input  wire logic                       bus_fault_precise,
   input  wire logic                       bus_fault_imprecise,
   input  wire logic                       usage_fault_req,
   input  wire logic                       svc_req,
   input  wire logic                       debug_mon_req,
   input  wire logic                       system_tick_exception_fire,
   // Core handshake
   input  wire logic                       first_instr,
   input  wire logic                       exc_ack,
   input  wire logic                       exc_ret,
   output logic                            exc_valid,
   output logic      [epc_pkg::POS_W-1:0]  exc_num,
   output logic                            exc_tail,
   output logic                            stack_save,
   output logic                            state_restore,
   output logic                            handler_mode,
   output logic                            sp_fetch,
   output logic                            reset_active
);

   typedef struct packed {
      epc_pkg::epc_fsm_e              fsm;
      logic [31:0]                    irq_s1;
      logic [31:0]                    irq_s2;
      logic [31:0]                    en;
      logic [47:0]                    pend;
      logic [47:0]                    act;
      logic [95:0]                    ipri;
      logic [epc_pkg::SYS_PRI_W-1:0]  spri;
      logic [epc_pkg::HC_W-1:0]       hc;
      logic [epc_pkg::SPLIT_W-1:0]    subb;
      logic                           valid;
      logic                           tail;
      logic                           save;
      logic                           restore;
      logic                           handler;
      logic                           sp_fetch;
      logic [epc_pkg::POS_W-1:0]      num;
      logic [31:0]                    rdata;
   } epc_state_s;

   localparam epc_state_s ST_RESET = '{
      fsm:      epc_pkg::EPC_SP_LOAD,
      ipri:     {32{epc_pkg::PRI_RESET}},
      spri:     {7{epc_pkg::PRI_RESET}},
      default:  '0
   };

   epc_state_s s_r;
   epc_state_s s_nxt;

   logic [3:0]  kfull [epc_pkg::NUM_POS];
   logic [3:0]  kgrp  [epc_pkg::NUM_POS];
   logic [47:0] elig;
   logic [2:0]  gmask;
   logic [2:0]  pr;
   logic [3:0]  fk;
   logic        fixed;
   logic        enb;
   int          sl;
   logic [3:0]  cur;
   logic [3:0]  lvl2;
   logic [5:0]  curpos;
   logic [5:0]  win;
   logic [3:0]  wk;
   logic        found;
   logic        preempt;
   logic [2:0]  wrd;

   always_comb begin
      s_nxt   = s_r;
      gmask   = 3'(3'h7 << s_r.subb);
      pr      = 3'h0;
      fk      = epc_pkg::KEY_IDLE;
      fixed   = 1'b1;
      enb     = 1'b0;
      sl      = 0;
      elig    = '0;
      cur     = epc_pkg::KEY_IDLE;
      lvl2    = epc_pkg::KEY_IDLE;
      curpos  = '0;
      win     = '0;
      wk      = epc_pkg::KEY_IDLE;
      found   = 1'b0;
      wrd     = reg_addr[4:2];
      s_nxt.save     = 1'b0;
      s_nxt.restore  = 1'b0;
      s_nxt.sp_fetch = 1'b0;
      s_nxt.rdata    = '0;

      // Only the second stage is read by the logic below
      s_nxt.irq_s1 = irq_lines;
      s_nxt.irq_s2 = s_r.irq_s1;

      // Priority key and eligibility per position
      for (int p = 0; p < epc_pkg::NUM_POS; p++) begin
         fixed = 1'b1;
         fk    = epc_pkg::KEY_IDLE;
         pr    = 3'h0;
         enb   = 1'b0;
         sl    = -1;
         if (p == epc_pkg::POS_RESET) begin
            fk  = epc_pkg::KEY_RESET;
            enb = 1'b1;
         end else if (p == epc_pkg::POS_NMI) begin
            fk  = epc_pkg::KEY_NMI;
            enb = 1'b1;
         end else if (p == epc_pkg::POS_HARD) begin
            fk  = epc_pkg::KEY_HARD;
            enb = 1'b1;
         end else if (p >= epc_pkg::POS_IRQ0) begin
            fixed = 1'b0;
            pr    = s_r.ipri[(p-epc_pkg::POS_IRQ0)*3 +: 3];
            enb   = s_r.en[p-epc_pkg::POS_IRQ0] & epc_pkg::IRQ_VALID_MASK[p-epc_pkg::POS_IRQ0];
         end else begin
            case (p)
               epc_pkg::POS_MEM: begin
                  sl  = 0;
                  enb = s_r.hc[epc_pkg::HC_MEM_EN];
               end
               epc_pkg::POS_BUS: begin
                  sl  = 1;
                  enb = s_r.hc[epc_pkg::HC_BUS_EN];
               end
               epc_pkg::POS_USAGE: begin
                  sl  = 2;
                  enb = s_r.hc[epc_pkg::HC_USE_EN];
               end
               epc_pkg::POS_SVC: begin
                  sl  = 3;
                  enb = 1'b1;
               end
               epc_pkg::POS_DBG: begin
                  sl  = 4;
                  enb = s_r.hc[epc_pkg::HC_DBG_EN];
               end
               epc_pkg::POS_PSV: begin
                  sl  = 5;
                  enb = 1'b1;
               end
               epc_pkg::POS_TICK: begin
                  sl  = 6;
                  enb = 1'b1;
               end
               default: begin
                  sl  = -1;
                  enb = 1'b0;
               end
            endcase
            if (sl >= 0) begin
               fixed = 1'b0;
               pr    = s_r.spri[sl*3 +: 3];
            end
         end
         // Settable zero lands just below the three fixed keys
         kfull[p] = fixed ? fk : 4'(epc_pkg::KEY_SETTABLE + {1'b0, pr});
         kgrp[p]  = fixed ? fk : 4'(epc_pkg::KEY_SETTABLE + {1'b0, pr & gmask});
         elig[p]  = s_r.pend[p] & enb;
      end

      // Current execution level and the handler that owns it
      for (int p = 0; p < epc_pkg::NUM_POS; p++) begin
         if (s_r.act[p] && kgrp[p] < cur) begin
            cur    = kgrp[p];
            curpos = 6'(p);
         end
      end
      for (int p = 0; p < epc_pkg::NUM_POS; p++) begin
         if (s_r.act[p] && 6'(p) != curpos && kgrp[p] < lvl2) begin
            lvl2 = kgrp[p];
         end
      end
      if (s_r.fsm != epc_pkg::EPC_RUN) begin
         cur = epc_pkg::KEY_RESET;
      end

      // Strict compare keeps the lower position on a tie
      for (int p = 0; p < epc_pkg::NUM_POS; p++) begin
         if (elig[p] && (!found || kfull[p] < wk)) begin
            found = 1'b1;
            wk    = kfull[p];
            win   = 6'(p);
         end
      end
      preempt = found && kgrp[win] < cur;

      // Clears first, so a same-cycle set wins
      if (reg_wr) begin
         if (reg_addr == epc_pkg::OFS_EN_CLR) begin
            s_nxt.en = s_r.en & ~reg_wdata;
         end else if (reg_addr == epc_pkg::OFS_PEND_CLR) begin
            s_nxt.pend[47:16] = s_r.pend[47:16] & ~reg_wdata;
         end else if (reg_addr == epc_pkg::OFS_CTRL_STATE) begin
            if (reg_wdata[epc_pkg::CS_PSV_CLR]) begin
               s_nxt.pend[epc_pkg::POS_PSV] = 1'b0;
            end
         end
      end
      if (exc_ack && s_r.valid) begin
         s_nxt.pend[s_r.num] = 1'b0;
      end

      // Register writes that set or load
      if (reg_wr) begin
         if (reg_addr == epc_pkg::OFS_EN_SET) begin
            s_nxt.en = s_r.en | (reg_wdata & epc_pkg::IRQ_VALID_MASK);
         end else if (reg_addr == epc_pkg::OFS_PEND_SET) begin
            s_nxt.pend[47:16] = s_nxt.pend[47:16] | (reg_wdata & epc_pkg::IRQ_VALID_MASK);
         end else if (reg_addr == epc_pkg::OFS_CTRL_STATE) begin
            if (reg_wdata[epc_pkg::CS_NMI_SET]) begin
               s_nxt.pend[epc_pkg::POS_NMI] = 1'b1;
            end
            if (reg_wdata[epc_pkg::CS_PSV_SET]) begin
               s_nxt.pend[epc_pkg::POS_PSV] = 1'b1;
            end
         end else if (reg_addr == epc_pkg::OFS_HND_CTRL) begin
            s_nxt.hc = reg_wdata[epc_pkg::HC_W-1:0];
         end else if (reg_addr == epc_pkg::OFS_PRI_SPLIT) begin
            s_nxt.subb = reg_wdata[epc_pkg::SPLIT_W-1:0];
         end else if (reg_addr == epc_pkg::OFS_SYS_PRI) begin
            s_nxt.spri = reg_wdata[epc_pkg::SYS_PRI_W-1:0];
         end else if (reg_addr >= epc_pkg::OFS_INT_PRI && reg_addr <= epc_pkg::OFS_INT_PRI_END) begin
            for (int j = 0; j < 4; j++) begin
               s_nxt.ipri[(wrd*4+j)*3 +: 3] = reg_wdata[8*j +: 3];
            end
         end
      end

      // Peripheral lines pend while high
      s_nxt.pend[47:16] = s_nxt.pend[47:16] | (s_r.irq_s2 & epc_pkg::IRQ_VALID_MASK);

      // Synchronous faults escalate when disabled or blocked by level
      if (mem_fault_req) begin
         if (s_r.hc[epc_pkg::HC_MEM_EN] && kgrp[epc_pkg::POS_MEM] < cur) begin
            s_nxt.pend[epc_pkg::POS_MEM] = 1'b1;
         end else begin
            s_nxt.pend[epc_pkg::POS_HARD] = 1'b1;
         end
      end
      if (bus_fault_precise) begin
         if (s_r.hc[epc_pkg::HC_BUS_EN] && kgrp[epc_pkg::POS_BUS] < cur) begin
            s_nxt.pend[epc_pkg::POS_BUS] = 1'b1;
         end else begin
            s_nxt.pend[epc_pkg::POS_HARD] = 1'b1;
         end
      end
      // Imprecise faults wait as pending when only the level blocks them
      if (bus_fault_imprecise) begin
         if (s_r.hc[epc_pkg::HC_BUS_EN]) begin
            s_nxt.pend[epc_pkg::POS_BUS] = 1'b1;
         end else begin
            s_nxt.pend[epc_pkg::POS_HARD] = 1'b1;
         end
      end
      if (usage_fault_req) begin
         if (s_r.hc[epc_pkg::HC_USE_EN] && kgrp[epc_pkg::POS_USAGE] < cur) begin
            s_nxt.pend[epc_pkg::POS_USAGE] = 1'b1;
         end else begin
            s_nxt.pend[epc_pkg::POS_HARD] = 1'b1;
         end
      end
      if (svc_req) begin
         if (kgrp[epc_pkg::POS_SVC] < cur) begin
            s_nxt.pend[epc_pkg::POS_SVC] = 1'b1;
         end else begin
            s_nxt.pend[epc_pkg::POS_HARD] = 1'b1;
         end
      end
      if (debug_mon_req && s_r.hc[epc_pkg::HC_DBG_EN]) begin
         s_nxt.pend[epc_pkg::POS_DBG] = 1'b1;
      end
      if (system_tick_exception_fire) begin
         s_nxt.pend[epc_pkg::POS_TICK] = 1'b1;
      end
      s_nxt.pend[15:0] = s_nxt.pend[15:0] & 16'hd87c;

      // Core sequencing
      case (s_r.fsm)
         epc_pkg::EPC_SP_LOAD: begin
            s_nxt.sp_fetch = 1'b1;
            s_nxt.fsm      = epc_pkg::EPC_RESET_RUN;
         end
         epc_pkg::EPC_RESET_RUN: begin
            if (first_instr) begin
               s_nxt.fsm = epc_pkg::EPC_RUN;
            end
         end
         default: begin
            if (exc_ack && s_r.valid) begin
               s_nxt.act[s_r.num] = 1'b1;
               s_nxt.save         = !s_r.tail;
               s_nxt.tail         = 1'b0;
            end else if (exc_ret && |s_r.act) begin
               s_nxt.act[curpos] = 1'b0;
               // Chain only when the winner outranks what remains
               if (found && kgrp[win] < lvl2) begin
                  s_nxt.tail = 1'b1;
               end else begin
                  s_nxt.restore = 1'b1;
               end
            end
         end
      endcase
      s_nxt.handler = |s_nxt.act;
      s_nxt.valid   = preempt && s_r.fsm == epc_pkg::EPC_RUN && !exc_ack && !exc_ret;
      s_nxt.num     = preempt ? win : '0;

      // Read data appear in the cycle after the strobe
      if (reg_rd) begin
         if (reg_addr == epc_pkg::OFS_EN_SET || reg_addr == epc_pkg::OFS_EN_CLR) begin
            s_nxt.rdata = s_r.en;
         end else if (reg_addr == epc_pkg::OFS_PEND_SET || reg_addr == epc_pkg::OFS_PEND_CLR) begin
            s_nxt.rdata = s_r.pend[47:16];
         end else if (reg_addr == epc_pkg::OFS_ACTIVE) begin
            s_nxt.rdata = s_r.act[47:16];
         end else if (reg_addr == epc_pkg::OFS_CTRL_STATE) begin
            s_nxt.rdata[epc_pkg::CS_NMI_SET]             = s_r.pend[epc_pkg::POS_NMI];
            s_nxt.rdata[epc_pkg::CS_PSV_SET]             = s_r.pend[epc_pkg::POS_PSV];
            s_nxt.rdata[epc_pkg::CS_PEND_LSB +: 6]       = found ? win : 6'h00;
            s_nxt.rdata[epc_pkg::CS_ACT_LSB +: 6]        = curpos;
         end else if (reg_addr == epc_pkg::OFS_HND_CTRL) begin
            s_nxt.rdata[epc_pkg::HC_W-1:0] = s_r.hc;
         end else if (reg_addr == epc_pkg::OFS_PRI_SPLIT) begin
            s_nxt.rdata[epc_pkg::SPLIT_W-1:0] = s_r.subb;
         end else if (reg_addr == epc_pkg::OFS_SYS_PRI) begin
            s_nxt.rdata[epc_pkg::SYS_PRI_W-1:0] = s_r.spri;
         end else if (reg_addr >= epc_pkg::OFS_INT_PRI && reg_addr <= epc_pkg::OFS_INT_PRI_END) begin
            for (int j = 0; j < 4; j++) begin
               s_nxt.rdata[8*j +: 3] = s_r.ipri[(wrd*4+j)*3 +: 3];
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_r <= ST_RESET;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata     = s_r.rdata;
   assign exc_valid     = s_r.valid;
   assign exc_num       = s_r.num;
   assign exc_tail      = s_r.tail;
   assign stack_save    = s_r.save;
   assign state_restore = s_r.restore;
   assign handler_mode  = s_r.handler;
   assign sp_fetch      = s_r.sp_fetch;
   assign reset_active  = (s_r.fsm != epc_pkg::EPC_RUN);

endmodule // epc_ctrl

// >>> rtl/epc_pkg.sv
// Purpose: Shared constants and types of the exception priority controller.
// Assumes: Register offsets are byte addresses on the plain register port.
// Notes:   Priority keys: smaller key means more urgent.
package epc_pkg;

   localparam int NUM_POS   = 48;
   localparam int NUM_IRQ   = 32;
   localparam int PRI_W     = 3;
   localparam int POS_W     = 6;
   localparam int ADDR_W    = 8;

   // Register offsets
   localparam logic [7:0] OFS_EN_SET     = 8'h00;
   localparam logic [7:0] OFS_EN_CLR     = 8'h04;
   localparam logic [7:0] OFS_PEND_SET   = 8'h08;
   localparam logic [7:0] OFS_PEND_CLR   = 8'h0c;
   localparam logic [7:0] OFS_ACTIVE     = 8'h10;
   localparam logic [7:0] OFS_CTRL_STATE = 8'h14;
   localparam logic [7:0] OFS_HND_CTRL   = 8'h18;
   localparam logic [7:0] OFS_PRI_SPLIT  = 8'h1c;
   localparam logic [7:0] OFS_SYS_PRI    = 8'h20;
   localparam logic [7:0] OFS_INT_PRI    = 8'h40;
   localparam logic [7:0] OFS_INT_PRI_END = 8'h5c;

   // Control and state register fields
   localparam int CS_NMI_SET   = 31;
   localparam int CS_PSV_SET   = 28;
   localparam int CS_PSV_CLR   = 27;
   localparam int CS_PEND_LSB  = 12;
   localparam int CS_ACT_LSB   = 0;

   // Handler control enables
   localparam int HC_MEM_EN = 0;
   localparam int HC_BUS_EN = 1;
   localparam int HC_USE_EN = 2;
   localparam int HC_DBG_EN = 3;
   localparam int HC_W      = 4;
   localparam int SPLIT_W   = 2;
   localparam int SYS_PRI_W = 21;

   // Exception positions
   localparam int POS_SP      = 0;
   localparam int POS_RESET   = 1;
   localparam int POS_NMI     = 2;
   localparam int POS_HARD    = 3;
   localparam int POS_MEM     = 4;
   localparam int POS_BUS     = 5;
   localparam int POS_USAGE   = 6;
   localparam int POS_SVC     = 11;
   localparam int POS_DBG     = 12;
   localparam int POS_PSV     = 14;
   localparam int POS_TICK    = 15;
   localparam int POS_IRQ0    = 16;

   // Implemented peripheral lines: 0-12, 14-24, 28, 29
   localparam logic [31:0] IRQ_VALID_MASK = 32'h31ffdfff;

   // Priority keys
   localparam logic [3:0] KEY_RESET    = 4'h0;
   localparam logic [3:0] KEY_NMI      = 4'h1;
   localparam logic [3:0] KEY_HARD     = 4'h2;
   localparam logic [3:0] KEY_SETTABLE = 4'h3;
   localparam logic [3:0] KEY_IDLE     = 4'hf;
   localparam logic [2:0] PRI_RESET    = 3'h0;

   typedef enum logic [1:0] {
      EPC_SP_LOAD,
      EPC_RESET_RUN,
      EPC_RUN
   } epc_fsm_e;

endpackage

// >>> verif/epc_ctrl_monitor.sv
// Purpose: Port checker for the exception priority controller.
// Assumes: One clock domain; rst_n synchronous, active low.
// Notes:   Bound to every epc_ctrl by the statement at the foot.
`timescale 1ns/1ps
module epc_ctrl_monitor (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        ce,
   // Register port
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Core handshake
   input wire logic        first_instr,
   input wire logic        exc_ack,
   input wire logic        exc_ret,
   input wire logic        exc_valid,
   input wire logic [5:0]  exc_num,
   input wire logic        exc_tail,
   input wire logic        stack_save,
   input wire logic        state_restore,
   input wire logic        handler_mode,
   input wire logic        sp_fetch,
   input wire logic        reset_active
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_sp_fetch_pulse: assert property (sp_fetch |-> reset_active ##1 !sp_fetch)
      else $error("stack pointer fetch is not a single pulse in reset");
   a_no_offer_reset: assert property (reset_active |-> !exc_valid)
      else $error("exception offered before first instruction");
   a_reset_drops: assert property (reset_active && first_instr && ce |-> ##[1:2] !reset_active)
      else $error("reset level kept after first instruction");
   a_ack_drops: assert property (exc_valid && exc_ack && ce |=> !exc_valid)
      else $error("offer not withdrawn after acknowledge");
   a_entry_saves: assert property (exc_valid && exc_ack && !exc_tail && ce |=> stack_save && handler_mode)
      else $error("entry without state save");
   a_chain_no_save: assert property (exc_valid && exc_ack && exc_tail && ce |=> !stack_save && handler_mode)
      else $error("tail chain saved state again");
   a_save_cause: assert property (stack_save |-> $past(exc_ack && exc_valid))
      else $error("state save without acknowledge");
   a_restore_cause: assert property (state_restore |-> $past(exc_ret))
      else $error("state restore without return");
   a_legal_pos: assert property (exc_valid |-> (exc_num inside {6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0b,
      6'h0c, 6'h0e, 6'h0f}) || (exc_num >= 6'h10 && epc_pkg::IRQ_VALID_MASK[exc_num - 6'h10]))
      else $error("reserved exception position offered");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read answer cycle");
   c_tail: cover property (exc_valid && exc_tail && exc_ack);
   c_nmi: cover property (exc_valid && exc_num == 6'h02);
   c_restore: cover property (state_restore);
endmodule // epc_ctrl_monitor

bind epc_ctrl epc_ctrl_monitor u_mon (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .first_instr(first_instr), .exc_ack(exc_ack), .exc_ret(exc_ret), .exc_valid(exc_valid), .exc_num(exc_num),
   .exc_tail(exc_tail), .stack_save(stack_save), .state_restore(state_restore), .handler_mode(handler_mode),
   .sp_fetch(sp_fetch), .reset_active(reset_active));

// >>> verif/epc_core_model.sv
// Purpose: Processor core stand-in: first instruction and exception acknowledge.
// Assumes: Offers are held until acknowledged.
// Notes:   Slow mode waits three extra cycles before taking an offer.
`timescale 1ns/1ps
module epc_core_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Controller side
   input wire logic exc_valid,
   input wire logic sp_fetch,
   input wire logic slow,
   output logic     first_instr,
   output logic     exc_ack
);
   logic [2:0] fi_cnt;
   logic [2:0] wait_cnt;
   always_ff @(posedge mclk) begin
      first_instr <= 1'b0;
      exc_ack <= 1'b0;
      if (!rst_n) begin
         fi_cnt <= 3'h0;
         wait_cnt <= 3'h0;
      end else begin
         if (sp_fetch) fi_cnt <= 3'h4;
         else if (fi_cnt != 3'h0) begin
            fi_cnt <= fi_cnt - 3'h1;
            first_instr <= (fi_cnt == 3'h1);
         end
         // Never acks twice: the offer drops one cycle after a take
         if (exc_valid && !exc_ack) begin
            wait_cnt <= wait_cnt + 3'h1;
            exc_ack <= (wait_cnt >= (slow ? 3'h3 : 3'h0));
         end else wait_cnt <= 3'h0;
      end
   end
endmodule // epc_core_model

// >>> verif/epc_ctrl_tb.sv
// Purpose: Self-checking bench for the exception priority controller.
// Assumes: Core stand-in acks every offer; bench drives lines, events, returns.
// Notes:   Taken offers are queued as {tail, position}.
`timescale 1ns/1ps
module epc_ctrl_tb;
   logic mclk, rst_n, ce, reg_wr, reg_rd, slow, exc_ret, first_instr, exc_ack;
   logic exc_valid, exc_tail, stack_save, state_restore, handler_mode, sp_fetch, reset_active;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, irq_lines;
   logic [6:0] ev;
   logic [5:0] exc_num;
   logic [6:0] taken[$];
   int miscompares, n_checks, cyc, n_save, n_rest, n_sp;
   epc_ctrl dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_lines(irq_lines),
      .mem_fault_req(ev[0]), .bus_fault_precise(ev[1]), .bus_fault_imprecise(ev[2]), .usage_fault_req(ev[3]),
      .svc_req(ev[4]), .debug_mon_req(ev[5]), .system_tick_exception_fire(ev[6]), .first_instr(first_instr),
      .exc_ack(exc_ack), .exc_ret(exc_ret), .exc_valid(exc_valid), .exc_num(exc_num), .exc_tail(exc_tail),
      .stack_save(stack_save), .state_restore(state_restore), .handler_mode(handler_mode),
      .sp_fetch(sp_fetch), .reset_active(reset_active));
   epc_core_model core (.mclk(mclk), .rst_n(rst_n), .exc_valid(exc_valid), .sp_fetch(sp_fetch),
      .slow(slow), .first_instr(first_instr), .exc_ack(exc_ack));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic complete_run;
      if (miscompares == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (exc_valid && exc_ack) taken.push_back({exc_tail, exc_num});
      if (stack_save) n_save++;
      if (state_restore) n_rest++;
      if (sp_fetch) n_sp++;
      if (cyc == 20000) begin
         miscompares++;
         complete_run();
      end
   end
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic take(logic [6:0] e);
      for (int i = 0; i < 60 && taken.size() == 0; i++) @(posedge mclk);
      chk(taken.size() != 0 ? {25'h0, taken.pop_front()} : 32'hffff_ffff, {25'h0, e});
   endtask
   task automatic quiet;
      repeat (8) @(posedge mclk);
      chk(taken.size(), 0);
   endtask
   task automatic ret;
      @(posedge mclk);
      exc_ret <= 1'b1;
      @(posedge mclk);
      exc_ret <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask
   // Level lines re-pend while high, so drop the line and clear its pending bit
   task automatic drop(logic [31:0] keep, logic [31:0] clr);
      @(posedge mclk);
      irq_lines <= keep;
      repeat (3) @(posedge mclk);
      wr(8'h0c, clr);
   endtask
   task automatic t_reset;
      chk(n_sp, 1);
      chk(reset_active, 0);
      rd(8'h20, 0);
      for (int k = 0; k < 8; k++) rd(8'h40 + 8'(k * 4), 0);
      rd(8'h18, 0);
      wr(8'h00, 32'hffff_ffff);
      rd(8'h00, epc_pkg::IRQ_VALID_MASK);
      wr(8'h04, 32'hffff_ffff);
      rd(8'h04, 0);
      wr(8'h08, 32'hffff_ffff);
      rd(8'h08, epc_pkg::IRQ_VALID_MASK);
      wr(8'h0c, 32'hffff_ffff);
      // A write while the clock enable is low must be lost
      ce <= 1'b0;
      wr(8'h18, 32'hf);
      ce <= 1'b1;
      rd(8'h18, 0);
      rd(8'h30, 0);
   endtask
   task automatic t_tie;
      int r0;
      wr(8'h40, 32'h0000_0101);
      wr(8'h00, 32'h3);
      @(posedge mclk);
      irq_lines <= 32'h3;
      take(7'h10);
      rd(8'h10, 32'h1);
      drop(32'h2, 32'h1);
      ret();
      take(7'h51);
      drop(32'h0, 32'h2);
      r0 = n_rest;
      ret();
      chk(n_rest, r0 + 1);
      quiet();
      chk(handler_mode, 0);
   endtask
   task automatic t_preempt;
      int s0;
      wr(8'h20, 32'h001c_0000);
      wr(8'h40, 32'h0);
      wr(8'h00, 32'h1);
      @(posedge mclk);
      irq_lines <= 32'h1;
      take(7'h10);
      drop(32'h0, 32'h1);
      @(posedge mclk);
      ev <= 7'h40;
      @(posedge mclk);
      ev <= 7'h00;
      quiet();
      s0 = n_save;
      wr(8'h14, 32'h8000_0000);
      take(7'h02);
      repeat (2) @(posedge mclk);
      chk(n_save, s0 + 1);
      chk(handler_mode, 1);
      ret();
      quiet();
      ret();
      take(7'h4f);
      ret();
   endtask
   task automatic t_events;
      logic [5:0] e0[7] = '{6'h03, 6'h03, 6'h03, 6'h03, 6'h0b, 6'h00, 6'h0f};
      logic [5:0] e1[7] = '{6'h04, 6'h05, 6'h05, 6'h06, 6'h0b, 6'h0c, 6'h0f};
      logic [5:0] e;
      wr(8'h20, 32'h0);
      for (int p = 0; p < 2; p++) begin
         wr(8'h18, p != 0 ? 32'hf : 32'h0);
         slow <= (p != 0);
         for (int i = 0; i < 7; i++) begin
            e = (p != 0) ? e1[i] : e0[i];
            @(posedge mclk);
            ev <= 7'h01 << i;
            @(posedge mclk);
            ev <= 7'h00;
            if (e == 6'h00) quiet();
            else take({1'b0, e});
            ret();
         end
      end
      wr(8'h14, 32'h1000_0000);
      take(7'h0e);
      ret();
   endtask
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      irq_lines = 32'h0;
      ev = 7'h00;
      exc_ret = 1'b0;
      slow = 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 50 && reset_active !== 1'b0; i++) @(posedge mclk);
      t_reset();
      t_tie();
      t_preempt();
      t_events();
      complete_run();
   end
endmodule // epc_ctrl_tb
